//--- design/aca_ctrl.sv
// Behaviour
// - ADC master enable bit gates all conversions
// - Sample mode bursts periodically at programmed interval
// - Sample mode inactive in reset or sleep
// - Burst interval is two-power-field times half-second
// - Configuration bits 5 to 3 reserved, read zero
// - Accumulator master enable gates every accumulation
// - Current enable adds results to discharge/charge totals
// - Time counters advance per current direction
// - Current enable off freezes totals and counters
// - Time counters advance on internal 2 Hz tick
// - Temperature source select: internal zero, external one
// - Cell-2 enable adds each cell-2 result
`timescale 1ns/10ps
`include "aca_consts.svh"

module aca_ctrl #(
   parameter int unsigned TICK_CYCLES = `ACA_TICK_CYCLES
) (
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   input  wire logic [`ACA_ADDR_W-1:0]        reg_addr,
   input  wire logic                          reg_wr,
   input  wire logic [7:0]                    reg_wdata,
   output logic      [7:0]                    reg_rdata,
   input  wire logic                          por_active,
   input  wire logic                          sleep_active,
   input  wire aca_pkg::aca_results_t         results,
   input  wire aca_pkg::aca_done_t            done,
   input  wire logic                          burst_done,
   output logic                               conversion_enable,
   output logic                               burst_start,
   output aca_pkg::aca_mode_t                 mode,
   output aca_pkg::aca_totals_t               totals
);
   import aca_pkg::*;

   if (TICK_CYCLES < 2 || TICK_CYCLES > 32'hffff_ffff)
   begin : g_tick_check
      $error("TICK_CYCLES out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0]  cfg_reg;
   logic [7:0]  acc_reg;
   logic [31:0] div_reg;
   logic        tick;
   logic [6:0]  interval_reg;
   logic [6:0]  interval_limit;
   logic        current_neg_reg;
   logic        samp_ok;
   logic        acc_cur;
   logic        acc_tmp;
   logic        acc_c2;
   logic        temp_done_sel;
   logic [15:0] temp_sel_val;
   aca_mode_t   mode_next;
   logic [31:0] discharge_total_reg;
   logic [31:0] charge_total_reg;
   logic [31:0] discharge_time_count_reg;
   logic [31:0] charge_time_count_reg;
   logic [31:0] temp_total_reg;
   logic [31:0] temp_time_count_reg;
   logic [31:0] cell2_voltage_total_reg;

   // Reserved bits are never stored so they always read zero
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cfg_reg <= `ACA_ADC_CONFIG_RST;
      else if (reg_wr && reg_addr == `ACA_ADC_CONFIG_ADDR)
         cfg_reg <= reg_wdata & 8'hc7;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         acc_reg <= `ACA_ACCUM_CTRL_RST;
      else if (reg_wr && reg_addr == `ACA_ACCUM_CTRL_ADDR)
         acc_reg <= reg_wdata & 8'hf8;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else if (reg_addr == `ACA_ADC_CONFIG_ADDR)
         reg_rdata <= cfg_reg;
      else if (reg_addr == `ACA_ACCUM_CTRL_ADDR)
         reg_rdata <= acc_reg;
      else
         reg_rdata <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // 2 Hz tick shared by sampling interval and elapsed time counters
   always_ff @(posedge clk)
   begin
      if (sys_rst || tick)
         div_reg <= 32'h0000_0000;
      else
         div_reg <= div_reg + 32'h0000_0001;
   end
   assign tick = (div_reg == 32'(TICK_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////////
   assign samp_ok        = cfg_reg[`ACA_SAMPLE_EN_BIT] && !por_active && !sleep_active;
   assign interval_limit = 7'((8'h01 << cfg_reg[`ACA_INTERVAL_MSB:`ACA_INTERVAL_LSB]) - 8'h01);

   always_comb
   begin
      mode_next = mode;
      case (mode)
         ACA_OFF:
            if (cfg_reg[`ACA_ADC_EN_BIT] && samp_ok)
               mode_next = ACA_SAMPLE_WAIT;
            else if (cfg_reg[`ACA_ADC_EN_BIT] && !cfg_reg[`ACA_SAMPLE_EN_BIT])
               mode_next = ACA_RUN;
         ACA_RUN:
            if (!cfg_reg[`ACA_ADC_EN_BIT] || cfg_reg[`ACA_SAMPLE_EN_BIT])
               mode_next = ACA_OFF;
         ACA_SAMPLE_WAIT:
            if (!cfg_reg[`ACA_ADC_EN_BIT] || !samp_ok)
               mode_next = ACA_OFF;
            else if (tick && interval_reg == interval_limit)
               mode_next = ACA_SAMPLE_BURST;
         ACA_SAMPLE_BURST:
            if (!cfg_reg[`ACA_ADC_EN_BIT] || !samp_ok)
               mode_next = ACA_OFF;
            else if (burst_done)
               mode_next = ACA_SAMPLE_WAIT;
         default:
            mode_next = ACA_OFF;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         mode <= ACA_OFF;
      else
         mode <= mode_next;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || mode != ACA_SAMPLE_WAIT)
         interval_reg <= 7'h00;
      else if (tick)
         interval_reg <= (interval_reg == interval_limit) ? 7'h00 : interval_reg + 7'h01;
   end

   assign burst_start       = (mode == ACA_SAMPLE_WAIT) && (mode_next == ACA_SAMPLE_BURST);
   // Master enable low drops conversions in the same cycle
   assign conversion_enable = cfg_reg[`ACA_ADC_EN_BIT] && (mode == ACA_RUN || mode == ACA_SAMPLE_BURST);

   ////////////////////////////////////////////////////////////////////////////
   assign acc_cur       = acc_reg[`ACA_ACC_MASTER_BIT] && acc_reg[`ACA_ACC_CURRENT_BIT];
   assign acc_tmp       = acc_reg[`ACA_ACC_MASTER_BIT] && acc_reg[`ACA_ACC_TEMP_BIT];
   assign acc_c2        = acc_reg[`ACA_ACC_MASTER_BIT] && acc_reg[`ACA_ACC_CELL2_BIT];
   assign temp_done_sel = acc_reg[`ACA_TEMP_SEL_BIT] ? done.ext_temp_done : done.int_temp_done;
   assign temp_sel_val  = acc_reg[`ACA_TEMP_SEL_BIT] ? results.ext_temp_result : results.int_temp_result;

   // Direction of the latest current conversion steers the time counters
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         current_neg_reg <= 1'b0;
      else if (done.current_done)
         current_neg_reg <= results.current_result[15];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         discharge_total_reg <= 32'h0000_0000;
         charge_total_reg    <= 32'h0000_0000;
      end
      else if (acc_cur && done.current_done)
      begin
         // Sign-extend before subtracting so full-scale discharge cannot wrap
         if (results.current_result[15])
            discharge_total_reg <= discharge_total_reg - 32'($signed(results.current_result));
         else
            charge_total_reg <= charge_total_reg + 32'(results.current_result);
      end
   end

   // Rollover is left to host maintenance, as with all totals
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         discharge_time_count_reg <= 32'h0000_0000;
         charge_time_count_reg    <= 32'h0000_0000;
      end
      else if (acc_cur && tick)
      begin
         if (current_neg_reg)
            discharge_time_count_reg <= discharge_time_count_reg + 32'h0000_0001;
         else
            charge_time_count_reg <= charge_time_count_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         temp_total_reg <= 32'h0000_0000;
      else if (acc_tmp && temp_done_sel)
         temp_total_reg <= temp_total_reg + 32'(temp_sel_val);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         temp_time_count_reg <= 32'h0000_0000;
      else if (acc_tmp && tick)
         temp_time_count_reg <= temp_time_count_reg + 32'h0000_0001;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cell2_voltage_total_reg <= 32'h0000_0000;
      else if (acc_c2 && done.cell2_done)
         cell2_voltage_total_reg <= cell2_voltage_total_reg + 32'(results.cell2_voltage_result);
   end

   // One driver for the whole carrier, fields in package order
   assign totals = {discharge_total_reg, charge_total_reg, discharge_time_count_reg, charge_time_count_reg,
                    temp_total_reg, temp_time_count_reg, cell2_voltage_total_reg};

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   master_off_a : assert property (!cfg_reg[7] |-> !conversion_enable)
      else $error("conversion while master enable low");
   burst_timing_a : assert property (burst_start |-> tick && samp_ok && interval_reg == interval_limit)
      else $error("burst outside interval");
   sample_gate_a : assert property ((por_active || sleep_active) |=> mode != ACA_SAMPLE_BURST)
      else $error("sampling in reset or sleep");
   interval_cap_a : assert property (mode == ACA_SAMPLE_WAIT |-> interval_reg <= interval_limit)
      else $error("interval counter beyond limit");
   reserved_read_a : assert property ($past(reg_addr) == `ACA_ADC_CONFIG_ADDR |-> reg_rdata[5:3] == 3'h0)
      else $error("reserved bits read nonzero");
   master_hold_a : assert property (!acc_reg[7] |=> $stable(totals))
      else $error("accumulation with master off");
   charge_add_a : assert property (acc_cur && done.current_done && !results.current_result[15]
      |=> totals.charge_total == $past(totals.charge_total) + 32'($past(results.current_result)))
      else $error("charge total not updated");
   time_step_a : assert property (acc_cur && tick && current_neg_reg
      |=> totals.discharge_time_count == $past(totals.discharge_time_count) + 32'h1)
      else $error("discharge time not advanced");
   current_hold_a : assert property (!acc_reg[6] |=> $stable(totals.charge_total) && $stable(totals.discharge_total)
      && $stable(totals.charge_time_count) && $stable(totals.discharge_time_count))
      else $error("current totals moved while disabled");
   tick_only_a : assert property (!tick |=> $stable(totals.charge_time_count))
      else $error("time counter moved without tick");
   temp_source_a : assert property (acc_tmp && !acc_reg[3] && !done.int_temp_done
      |=> $stable(totals.temp_total))
      else $error("wrong temperature source accumulated");
   cell2_add_a : assert property (acc_c2 && done.cell2_done
      |=> totals.cell2_voltage_total
          == $past(totals.cell2_voltage_total) + 32'($past(results.cell2_voltage_result)))
      else $error("cell2 total not updated");
   // Leaving sample mode passes through OFF, so run needs two edges
   run_mode_a : assert property (cfg_reg[7] && !cfg_reg[6] ##1 cfg_reg[7] && !cfg_reg[6]
      ##1 cfg_reg[7] && !cfg_reg[6] |-> conversion_enable)
      else $error("continuous conversion missing");

   burst_seen_c : cover property (burst_start ##[1:100] burst_done);
   run_seen_c : cover property (mode == ACA_RUN && conversion_enable);
   discharge_c : cover property (acc_cur && done.current_done && results.current_result[15]);
   ext_temp_c : cover property (acc_tmp && acc_reg[3] && done.ext_temp_done);

endmodule

//--- design/aca_consts.svh
`ifndef ACA_CONSTS_SVH
`define ACA_CONSTS_SVH

// Register map on the management bus
`define ACA_ADDR_W            8
`define ACA_ADC_CONFIG_ADDR   8'h43
`define ACA_ACCUM_CTRL_ADDR   8'h63

// adc_configuration fields
`define ACA_ADC_EN_BIT        7
`define ACA_SAMPLE_EN_BIT     6
`define ACA_INTERVAL_MSB      2
`define ACA_INTERVAL_LSB      0
`define ACA_ADC_CONFIG_RST    8'h00

// accumulator_control fields
`define ACA_ACC_MASTER_BIT    7
`define ACA_ACC_CURRENT_BIT   6
`define ACA_ACC_TEMP_BIT      5
`define ACA_ACC_CELL2_BIT     4
`define ACA_TEMP_SEL_BIT      3
`define ACA_ACCUM_CTRL_RST    8'h00

// Timing: internal 2 Hz tick from the 100 MHz clock
`define ACA_CLK_PERIOD_NS     10
`define ACA_TICK_PERIOD_MS    500
`define ACA_TICK_CYCLES       ((`ACA_TICK_PERIOD_MS * 1000000) / `ACA_CLK_PERIOD_NS)

`endif

//--- design/aca_pkg.sv
package aca_pkg;

   typedef struct packed {
      logic [15:0] current_result;
      logic [15:0] cell2_voltage_result;
      logic [15:0] int_temp_result;
      logic [15:0] ext_temp_result;
   } aca_results_t;

   typedef struct packed {
      logic current_done;
      logic cell2_done;
      logic int_temp_done;
      logic ext_temp_done;
   } aca_done_t;

   typedef struct packed {
      logic [31:0] discharge_total;
      logic [31:0] charge_total;
      logic [31:0] discharge_time_count;
      logic [31:0] charge_time_count;
      logic [31:0] temp_total;
      logic [31:0] temp_time_count;
      logic [31:0] cell2_voltage_total;
   } aca_totals_t;

   typedef enum logic [1:0] {
      ACA_OFF,
      ACA_RUN,
      ACA_SAMPLE_WAIT,
      ACA_SAMPLE_BURST
   } aca_mode_t;

endpackage

//--- sim/test_adc_config_accum_control.sv
`timescale 1ns/10ps
module test_adc_config_accum_control;
   import aca_pkg::*;
   localparam int TICK = 10;
   logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, por_active = 1'b0, sleep_active = 1'b0, burst_done = 1'b0;
   logic [7:0]   reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   aca_results_t results = '0;
   aca_done_t    done = '0;
   logic         conversion_enable, burst_start;
   aca_mode_t    mode;
   aca_totals_t  totals, t0;
   int           err_count = 0, num_checks = 0, n;

   always #5 clk = ~clk;

   aca_ctrl #(.TICK_CYCLES(TICK)) i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .por_active(por_active), .sleep_active(sleep_active),
      .results(results), .done(done), .burst_done(burst_done), .conversion_enable(conversion_enable),
      .burst_start(burst_start), .mode(mode), .totals(totals));

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   task rd_check(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_addr = a;
      @(negedge clk);
      check("reg_rdata", 32'(reg_rdata), 32'(exp));
   endtask

   // Unbounded waits would hide a dead sampler, so give up after 3000
   task wait_burst(output int cnt);
      cnt = 0;
      while (burst_start !== 1'b1 && cnt < 3000)
      begin
         @(negedge clk);
         cnt++;
      end
   endtask

   task acc_pulse(input logic [7:0] ctrl, input logic [3:0] d, input logic [15:0] v);
      wr(8'h63, ctrl);
      t0 = totals;
      results = {4{v}};
      done = d;
      @(negedge clk);
      done = '0;
      @(negedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task test_regs;
      rd_check(8'h43, 8'h00);
      rd_check(8'h63, 8'h00);
      wr(8'h43, 8'h3f);
      rd_check(8'h43, 8'h07);
      wr(8'h63, 8'hff);
      rd_check(8'h63, 8'hf8);
      wr(8'h22, 8'hff);
      rd_check(8'h22, 8'h00);
      wr(8'h63, 8'h00);
   endtask

   task test_run;
      wr(8'h43, 8'h80);
      @(negedge clk);
      check("mode run", 32'(mode), 32'(ACA_RUN));
      check("conv on", 32'(conversion_enable), 32'h1);
      wr(8'h43, 8'h00);
      @(negedge clk);
      check("conv off", 32'(conversion_enable), 32'h0);
      check("mode off", 32'(mode), 32'(ACA_OFF));
   endtask

   task test_accum;
      acc_pulse(8'h40, 4'h8, 16'hfff0);
      check("dis gated", totals.discharge_total, t0.discharge_total);
      acc_pulse(8'hc0, 4'h8, 16'hfff0);
      check("dis add", totals.discharge_total, t0.discharge_total + 32'h10);
      acc_pulse(8'hc0, 4'h8, 16'h0005);
      check("chg add", totals.charge_total, t0.charge_total + 32'h5);
      acc_pulse(8'hc0, 4'h8, 16'h8000);
      check("dis full", totals.discharge_total, t0.discharge_total + 32'h8000);
      acc_pulse(8'h80, 4'h8, 16'h0005);
      check("chg frozen", totals.charge_total, t0.charge_total);
      acc_pulse(8'h90, 4'h4, 16'h0064);
      check("cell2 add", totals.cell2_voltage_total, t0.cell2_voltage_total + 32'h64);
      acc_pulse(8'h10, 4'h4, 16'h0064);
      check("cell2 gated", totals.cell2_voltage_total, t0.cell2_voltage_total);
      acc_pulse(8'ha0, 4'h2, 16'h0007);
      check("temp int", totals.temp_total, t0.temp_total + 32'h7);
      acc_pulse(8'ha0, 4'h1, 16'h0009);
      check("temp ext ign", totals.temp_total, t0.temp_total);
      acc_pulse(8'ha8, 4'h1, 16'h0009);
      check("temp ext", totals.temp_total, t0.temp_total + 32'h9);
   endtask

   task test_time;
      // Latest current negative, so of the current counters only discharge time may advance
      acc_pulse(8'he0, 4'h8, 16'hffff);
      t0 = totals;
      repeat (4 * TICK) @(negedge clk);
      check("dis time", totals.discharge_time_count, t0.discharge_time_count + 32'h4);
      check("chg time", totals.charge_time_count, t0.charge_time_count);
      check("temp time", totals.temp_time_count, t0.temp_time_count + 32'h4);
      wr(8'h63, 8'h80);
      t0 = totals;
      repeat (4 * TICK) @(negedge clk);
      check("time frozen", totals.discharge_time_count, t0.discharge_time_count);
      check("temp time frozen", totals.temp_time_count, t0.temp_time_count);
      // Latest current positive, so charge time takes over
      acc_pulse(8'hc0, 4'h8, 16'h0001);
      t0 = totals;
      repeat (4 * TICK) @(negedge clk);
      check("chg time adv", totals.charge_time_count, t0.charge_time_count + 32'h4);
      check("dis time held", totals.discharge_time_count, t0.discharge_time_count);
   endtask

   task test_sample;
      for (int s = 0; s < 8; s++)
      begin
         wr(8'h43, 8'h00);
         wr(8'h43, 8'hc0 | 8'(s));
         wait_burst(n);
         @(negedge clk);
         check("burst mode", 32'(mode), 32'(ACA_SAMPLE_BURST));
         check("burst conv", 32'(conversion_enable), 32'h1);
         burst_done = 1'b1;
         @(negedge clk);
         burst_done = 1'b0;
         wait_burst(n);
         check("interval", 32'(n + 2), 32'((1 << s) * TICK));
      end
      // Gate first, so sampling must never start at all
      for (int k = 0; k < 2; k++)
      begin
         por_active = (k == 0);
         sleep_active = (k == 1);
         wr(8'h43, 8'hc0);
         n = 0;
         repeat (3 * TICK)
         begin
            @(negedge clk);
            n += int'(burst_start === 1'b1);
         end
         check("gated mode", 32'(mode), 32'(ACA_OFF));
         check("gated bursts", 32'(n), 32'h0);
         wr(8'h43, 8'h00);
      end
      por_active = 1'b0;
      sleep_active = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      test_regs();
      test_run();
      test_accum();
      test_time();
      test_sample();
      finish_test();
   end

   // Whole run is about 5400 cycles; about a thirteenfold margin
   initial
   begin
      repeat (70000) @(posedge clk);
      err_count++;
      finish_test();
   end
endmodule
